// ==== rtl/css_cfg.svh ====
// Purpose: offsets, field positions, reset values and counts of the clock source switch
// Assumes: plain register port with a 4-bit address and 8-bit data
// Notes: definitions only, included by bare name
`ifndef CSS_CFG_SVH
`define CSS_CFG_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define CSS_ADDR_CTRL 4'h0
`define CSS_ADDR_STAT 4'h1
`define CSS_ADDR_MASK 4'h2

// ****************************************************************
// clock control register fields
// ****************************************************************
`define CSS_SCS_LSB 0
`define CSS_SCS_MSB 1
`define CSS_FAST_INTERNAL_STABLE_FLAG_BIT 2
`define CSS_PRIMARY_STABLE_FLAG_BIT 3
`define CSS_IRCF_LSB 4
`define CSS_IRCF_MSB 6
`define CSS_SEC_EN_BIT 7

// ****************************************************************
// event status bits (status and mask share the layout)
// ****************************************************************
`define CSS_EV_FAILSAFE 0
`define CSS_EV_SWITCH 1
`define CSS_EV_TWO_SPEED 2
`define CSS_EV_W 3

// ****************************************************************
// configuration word two bits
// ****************************************************************
`define CSS_FAIL_SAFE_MONITOR_ENABLE_BIT 0
`define CSS_TWO_SPEED_BIT 1

// ****************************************************************
// reset values
// ****************************************************************
`define CSS_SCS_RST 2'h0
`define CSS_IRCF_RST 3'h0
`define CSS_SEC_EN_RST 1'h0
`define CSS_STAT_RST 3'h0
`define CSS_MASK_RST 3'h0

// ****************************************************************
// counts, in primary clocks and in slow internal rc ticks
// ****************************************************************
`define CSS_OST_CLOCKS 11'h400
`define CSS_WAKE_EXTRA 11'h008
`define CSS_FAIL_LIMIT 4'h4

`endif

// ==== rtl/css_pkg.sv ====
// Purpose: types shared by the clock source switch
// Assumes: nothing beyond SystemVerilog packages
// Notes: numbers live in css_cfg.svh, only types here
package css_pkg;

   // ****************************************************************
   // active system clock source
   // ****************************************************************
   typedef enum logic [1:0] {
      SRC_PRIMARY,
      SRC_SECONDARY,
      SRC_INT_BLOCK,
      SRC_SLOW_RC
   } css_src_t;

   // ****************************************************************
   // internal block frequency, slowest to fastest
   // ****************************************************************
   typedef enum logic [2:0] {
      FRQ_31K25,
      FRQ_125K,
      FRQ_250K,
      FRQ_500K,
      FRQ_1M,
      FRQ_2M,
      FRQ_4M,
      FRQ_8M
   } css_freq_t;

   // ****************************************************************
   // primary oscillator mode from configuration word one
   // ****************************************************************
   typedef enum logic [2:0] {
      PM_LP,
      PM_XT,
      PM_HS,
      PM_EXT_CLK,
      PM_EXT_RC,
      PM_EXT_RC_IO,
      PM_INT_IO,
      PM_INT_CLKOUT
   } css_pmode_t;

   // one-cycle tick per oscillator edge, synchronous to the system clock
   typedef struct packed {
      logic primary;
      logic secondary;
      logic slow_rc;
   } css_ticks_t;

   // register port request
   typedef struct packed {
      logic wr_en;
      logic rd_en;
      logic [3:0] addr;
      logic [7:0] wdata;
   } css_req_t;

endpackage

// ==== rtl/css_clock_switch.sv ====
// Purpose: system clock source selection, fail-safe switch and two-speed start-up
// Assumes: oscillator ticks and power events arrive synchronous to clock_i
// Notes: sys_src_o steers the glitch-free clock mux that sits outside this block
//
// Summary of operation
// - select field 00 takes the primary oscillator set by configuration word one
// - select 01 routes the secondary oscillator, 10 the internal block
// - every reset forces the select field to 00
// - frequency field picks slow rc, fast oscillator or six postscaled rates
// - a frequency field write changes the internal mux output at once
// - primary-stable after start-up timer expiry; fast-stable when fast oscillator stable
// - fail-safe enabled and primary fails: switch to internal rc
// - fail-safe enabled and secondary fails: switch to internal rc
// - two-speed reset start runs slow rc, then hands over to primary
// - two-speed wake with crystal and select 00 hands over after 1024+8 clocks
// - a software change of the select field starts a clock switch
// - a software change of the frequency field starts a clock switch when running on the internal block
// - no switch on reset unless two-speed enabled and primary is a crystal
// - without two-speed, execution waits after reset until primary is stable
// - secondary oscillator keeps running in sleep
// - slow internal rc always runs for monitor, timers and start-up logic
// - primary mode is latched at power-on reset and held until the next one
`timescale 1ns/1ps
`include "css_cfg.svh"

module css_clock_switch
   import css_pkg::*;
(
   input wire logic clock_i,              // system clock, 25 MHz
   input wire logic sys_rst_i,            // any reset, synchronous, active high
   input wire logic por_i,                // high with sys_rst_i on power-on reset
   input wire logic [2:0] config_word_one_i, // primary oscillator mode bits
   input wire logic [1:0] config_word_two_i, // fail-safe and two-speed enables
   input wire css_ticks_t ticks_i,        // oscillator edge ticks
   input wire logic fast_osc_ready_i,     // fast internal oscillator is stable
   input wire logic sleep_i,              // pulse: sleep instruction executed
   input wire logic wake_i,               // pulse: interrupt or watchdog wake
   input wire css_req_t req_i,            // register access request
   output logic [7:0] rd_data_o,          // read data, cycle after the read
   output css_src_t sys_src_o,            // active system clock source
   output css_freq_t int_freq_o,          // internal block mux selection
   output logic cpu_run_o,                // instruction execution allowed
   output logic primary_osc_en_o,         // primary oscillator powered
   output logic secondary_osc_en_o,       // secondary oscillator powered
   output logic slow_rc_en_o,             // slow internal rc powered
   output logic irq_o                     // level interrupt
);

   // ****************************************************************
   // declarations
   // ****************************************************************
   typedef enum logic [2:0] {
      ST_BOOT,
      ST_HOLD,
      ST_TWO_SPEED,
      ST_RUN,
      ST_FAILSAFE,
      ST_SLEEP
   } css_state_t;

   css_state_t state_q, state_d;
   css_src_t src_q, src_d;
   logic run_q, run_d;
   logic wake_q, wake_d;
   css_pmode_t primary_osc_config_q;
   logic [1:0] cfg_two_q;
   logic [1:0] system_clock_select_q;
   css_freq_t internal_freq_select_q;
   logic sec_en_q;
   logic primary_stable_flag_q;
   logic fast_internal_stable_flag_q;
   logic [10:0] ost_cnt_q;
   logic [3:0] fail_cnt_q;
   logic [`CSS_EV_W-1:0] stat_q, mask_q, ev;
   logic [7:0] rd_data_q;
   logic crystal, fail_safe_monitor_enable, two_speed_en;
   logic ost_done, wake_done, fail_det, watch_tick;
   logic wr_ctrl, scs_chg, ircf_chg;
   logic [1:0] scs_new;
   css_freq_t ircf_new;

   // maps the select field onto a source; 11 falls in with 10
   function automatic css_src_t scs_to_src(input logic [1:0] scs);
      css_src_t s;
      unique case (scs)
         2'h0: s = SRC_PRIMARY;
         2'h1: s = SRC_SECONDARY;
         2'h2: s = SRC_INT_BLOCK;
         2'h3: s = SRC_INT_BLOCK;
      endcase
      return s;
   endfunction

   // ****************************************************************
   // configuration capture
   // ****************************************************************
   // mode is only taken at power-on, other resets must not disturb it
   always_ff @(posedge clock_i) begin
      if (sys_rst_i && por_i) begin
         primary_osc_config_q <= css_pmode_t'(config_word_one_i);
      end
   end

   // word two is reread on every reset
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         cfg_two_q <= config_word_two_i;
      end
   end

   assign crystal = (primary_osc_config_q == PM_LP) || (primary_osc_config_q == PM_XT) ||
                    (primary_osc_config_q == PM_HS);
   assign fail_safe_monitor_enable = cfg_two_q[`CSS_FAIL_SAFE_MONITOR_ENABLE_BIT];
   assign two_speed_en = cfg_two_q[`CSS_TWO_SPEED_BIT];

   // ****************************************************************
   // software writes to the control register
   // ****************************************************************
   assign wr_ctrl = req_i.wr_en && (req_i.addr == `CSS_ADDR_CTRL);
   assign scs_new = req_i.wdata[`CSS_SCS_MSB:`CSS_SCS_LSB];
   assign ircf_new = css_freq_t'(req_i.wdata[`CSS_IRCF_MSB:`CSS_IRCF_LSB]);
   assign scs_chg = wr_ctrl && (scs_new != system_clock_select_q);
   assign ircf_chg = wr_ctrl && (ircf_new != internal_freq_select_q);

   // select field cleared by every reset
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         system_clock_select_q <= `CSS_SCS_RST;
      end else if (wr_ctrl) begin
         system_clock_select_q <= scs_new;
      end
   end

   // frequency field feeds the mux directly, no settling wait
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         internal_freq_select_q <= css_freq_t'(`CSS_IRCF_RST);
      end else if (wr_ctrl) begin
         internal_freq_select_q <= ircf_new;
      end
   end

   // secondary enable is not touched by sleep, it is the power-managed time base
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         sec_en_q <= `CSS_SEC_EN_RST;
      end else if (wr_ctrl) begin
         sec_en_q <= req_i.wdata[`CSS_SEC_EN_BIT];
      end
   end

   // ****************************************************************
   // oscillator start-up timer and stable flags
   // ****************************************************************
   // counts primary edges; cleared in sleep since the primary is stopped there
   always_ff @(posedge clock_i) begin
      if (sys_rst_i || (state_q == ST_SLEEP)) begin
         ost_cnt_q <= 11'h000;
      end else if (ticks_i.primary && !wake_done) begin
         ost_cnt_q <= ost_cnt_q + 11'h001;
      end
   end

   assign ost_done = (ost_cnt_q >= `CSS_OST_CLOCKS);
   assign wake_done = (ost_cnt_q == (`CSS_OST_CLOCKS + `CSS_WAKE_EXTRA));

   // non-crystal primaries need no start-up timer
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         primary_stable_flag_q <= 1'b0;
      end else begin
         primary_stable_flag_q <= (state_q != ST_SLEEP) && (ost_done || !crystal);
      end
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         fast_internal_stable_flag_q <= 1'b0;
      end else begin
         fast_internal_stable_flag_q <= fast_osc_ready_i;
      end
   end

   // ****************************************************************
   // fail-safe clock monitor
   // ****************************************************************
   // timed by slow rc ticks so it keeps working when the watched clock is dead
   assign watch_tick = (src_q == SRC_PRIMARY) ? ticks_i.primary :
                       (src_q == SRC_SECONDARY) ? ticks_i.secondary : 1'b1;

   always_ff @(posedge clock_i) begin
      if (sys_rst_i || (state_q != ST_RUN) || watch_tick) begin
         fail_cnt_q <= 4'h0;
      end else if (ticks_i.slow_rc && !fail_det) begin
         fail_cnt_q <= fail_cnt_q + 4'h1;
      end
   end

   assign fail_det = (fail_cnt_q == `CSS_FAIL_LIMIT);

   // ****************************************************************
   // source sequencing
   // ****************************************************************
   // decides source, execution permission and switch events
   always_comb begin
      state_d = state_q;
      src_d = src_q;
      run_d = run_q;
      wake_d = wake_q;
      ev = '0;
      unique case (state_q)
         ST_BOOT: begin
            wake_d = 1'b0;
            if (crystal && two_speed_en) begin
               state_d = ST_TWO_SPEED;
               src_d = SRC_SLOW_RC;
               run_d = 1'b1;
            end else if (crystal) begin
               state_d = ST_HOLD;
               src_d = SRC_PRIMARY;
               run_d = 1'b0;
            end else begin
               state_d = ST_RUN;
               src_d = SRC_PRIMARY;
               run_d = 1'b1;
            end
         end
         ST_HOLD: begin
            if (ost_done) begin
               state_d = ST_RUN;
               run_d = 1'b1;
            end
         end
         ST_TWO_SPEED: begin
            if (sleep_i) begin
               state_d = ST_SLEEP;
               run_d = 1'b0;
            end else if (scs_chg) begin
               state_d = ST_RUN;
               src_d = scs_to_src(scs_new);
               ev[`CSS_EV_SWITCH] = 1'b1;
            end else if (wake_q ? wake_done : ost_done) begin
               state_d = ST_RUN;
               src_d = SRC_PRIMARY;
               ev[`CSS_EV_TWO_SPEED] = 1'b1;
            end
         end
         ST_RUN: begin
            if (sleep_i) begin
               state_d = ST_SLEEP;
               run_d = 1'b0;
            end else if (fail_safe_monitor_enable && fail_det) begin
               state_d = ST_FAILSAFE;
               src_d = SRC_SLOW_RC;
               ev[`CSS_EV_FAILSAFE] = 1'b1;
            end else if (scs_chg) begin
               src_d = scs_to_src(scs_new);
               ev[`CSS_EV_SWITCH] = 1'b1;
            end else if (ircf_chg && (src_q == SRC_INT_BLOCK)) begin
               ev[`CSS_EV_SWITCH] = 1'b1;
            end
         end
         ST_FAILSAFE: begin
            // stays on the rc until software picks a source again or a wake from sleep reselects from the select field
            if (sleep_i) begin
               state_d = ST_SLEEP;
               run_d = 1'b0;
            end else if (scs_chg) begin
               state_d = ST_RUN;
               src_d = scs_to_src(scs_new);
               ev[`CSS_EV_SWITCH] = 1'b1;
            end
         end
         ST_SLEEP: begin
            if (wake_i) begin
               if (two_speed_en && crystal && (system_clock_select_q == 2'h0)) begin
                  state_d = ST_TWO_SPEED;
                  src_d = SRC_SLOW_RC;
                  wake_d = 1'b1;
                  run_d = 1'b1;
               end else if (crystal && (system_clock_select_q == 2'h0)) begin
                  state_d = ST_HOLD;
                  src_d = SRC_PRIMARY;
               end else begin
                  state_d = ST_RUN;
                  src_d = scs_to_src(system_clock_select_q);
                  run_d = 1'b1;
               end
            end
         end
      endcase
   end

   // state, source and execution permission
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         state_q <= ST_BOOT;
         src_q <= SRC_PRIMARY;
         run_q <= 1'b0;
         wake_q <= 1'b0;
      end else begin
         state_q <= state_d;
         src_q <= src_d;
         run_q <= run_d;
         wake_q <= wake_d;
      end
   end

   // primary is stopped in sleep; slow rc and secondary are not
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         primary_osc_en_o <= 1'b1;
      end else begin
         primary_osc_en_o <= (state_d != ST_SLEEP);
      end
   end

   assign secondary_osc_en_o = sec_en_q;
   assign slow_rc_en_o = 1'b1;
   assign sys_src_o = src_q;
   assign int_freq_o = internal_freq_select_q;
   assign cpu_run_o = run_q;

   // ****************************************************************
   // interrupt status and mask
   // ****************************************************************
   // write one to clear; a new event in the same cycle wins
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         stat_q <= `CSS_STAT_RST;
      end else if (req_i.wr_en && (req_i.addr == `CSS_ADDR_STAT)) begin
         stat_q <= (stat_q & ~req_i.wdata[`CSS_EV_W-1:0]) | ev;
      end else begin
         stat_q <= stat_q | ev;
      end
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         mask_q <= `CSS_MASK_RST;
      end else if (req_i.wr_en && (req_i.addr == `CSS_ADDR_MASK)) begin
         mask_q <= req_i.wdata[`CSS_EV_W-1:0];
      end
   end

   assign irq_o = |(stat_q & mask_q);

   // ****************************************************************
   // register read
   // ****************************************************************
   // data stands only in the cycle after the strobe; unmapped reads give zero
   always_ff @(posedge clock_i) begin
      if (sys_rst_i || !req_i.rd_en) begin
         rd_data_q <= 8'h00;
      end else begin
         unique case (req_i.addr)
            `CSS_ADDR_CTRL: rd_data_q <= {sec_en_q, internal_freq_select_q,
                                          primary_stable_flag_q, fast_internal_stable_flag_q,
                                          system_clock_select_q};
            `CSS_ADDR_STAT: rd_data_q <= {5'h00, stat_q};
            `CSS_ADDR_MASK: rd_data_q <= {5'h00, mask_q};
            default: rd_data_q <= 8'h00;
         endcase
      end
   end

   assign rd_data_o = rd_data_q;

endmodule

// ==== test/css_osc_model.sv ====
// Purpose: behavioural oscillators feeding the clock source switch
// Assumes: ticks are one-cycle pulses synchronous to the system clock
// Notes: primary every 2 cycles, secondary every 4, slow rc every 8
`timescale 1ns/1ps
module css_osc_model
   import css_pkg::*;
#(
   parameter int FAST_DELAY = 16 // cycles until the fast oscillator settles
)(
   input wire logic clock_i, // system clock
   input wire logic prim_en_i, // primary powered
   input wire logic prim_ok_i, // primary healthy, low to fail it
   input wire logic sec_en_i, // secondary powered
   input wire logic sec_ok_i, // secondary healthy, low to fail it
   output css_ticks_t ticks_o, // oscillator edge ticks
   output logic fast_ready_o // fast internal oscillator stable
);
   logic [7:0] cnt_q;

   // quiet start so the switch never sees unknown ticks
   initial begin
      cnt_q = 8'h00;
      ticks_o = '0;
      fast_ready_o = 1'b0;
   end

   // unpowered or failed sources give no ticks
   always @(posedge clock_i) begin
      cnt_q <= cnt_q + 8'h01;
      ticks_o.primary <= prim_en_i && prim_ok_i && cnt_q[0];
      ticks_o.secondary <= sec_en_i && sec_ok_i && cnt_q[1:0] == 2'h3;
      ticks_o.slow_rc <= cnt_q[2:0] == 3'h7;
      fast_ready_o <= fast_ready_o || cnt_q >= FAST_DELAY;
   end
endmodule

// ==== test/css_clock_switch_asserts.sv ====
// Purpose: port-level checks of the clock source switch
// Assumes: one clock domain, synchronous active-high reset
// Notes: bound onto css_clock_switch below the module
`timescale 1ns/1ps
module css_clock_switch_asserts
   import css_pkg::*;
(
   input wire logic clock_i, // system clock
   input wire logic sys_rst_i, // any reset
   input wire logic [1:0] config_word_two_i, // monitor and two-speed enables
   input wire css_ticks_t ticks_i, // oscillator ticks
   input wire logic sleep_i, // sleep pulse
   input wire logic wake_i, // wake pulse
   input wire css_req_t req_i, // register request
   input wire logic [7:0] rd_data_o, // read data
   input wire css_src_t sys_src_o, // active source
   input wire css_freq_t int_freq_o, // internal mux code
   input wire logic cpu_run_o, // execution allowed
   input wire logic primary_osc_en_o, // primary powered
   input wire logic secondary_osc_en_o, // secondary powered
   input wire logic slow_rc_en_o // slow rc powered
);
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (sys_rst_i);

   logic ctl_wr;
   logic sw_ok;
   logic watch_tick;
   logic watched;
   logic [3:0] gap_q;
   css_src_t src_q;

   // select writes that a running source must follow
   assign ctl_wr = req_i.wr_en && req_i.addr == 4'h0;
   assign sw_ok = ctl_wr && cpu_run_o && !sleep_i && !wake_i && sys_src_o != SRC_SLOW_RC;
   assign watch_tick = (sys_src_o == SRC_PRIMARY) ? ticks_i.primary : ticks_i.secondary;
   assign watched = (sys_src_o == SRC_PRIMARY && primary_osc_en_o)
      || sys_src_o == SRC_SECONDARY;

   // slow rc ticks since the watched source last ticked
   always_ff @(posedge clock_i) begin
      src_q <= sys_src_o;
      if (sys_rst_i || watch_tick || src_q != sys_src_o) begin
         gap_q <= 4'h0;
      end else if (ticks_i.slow_rc && gap_q != 4'hF) begin
         gap_q <= gap_q + 4'h1;
      end
   end

   slow_rc_a: assert property (slow_rc_en_o)
      else $error("slow rc enable dropped");
   reset_a: assert property (disable iff (1'b0)
      sys_rst_i |=> sys_src_o == SRC_PRIMARY && !cpu_run_o)
      else $error("no primary after reset");
   rd_idle_a: assert property (!req_i.rd_en |=> rd_data_o == 8'h00)
      else $error("read data without a read");
   sel_sec_a: assert property (
      sw_ok && req_i.wdata[1:0] == 2'h1 |-> ##[1:2] sys_src_o == SRC_SECONDARY)
      else $error("select 01 missed secondary");
   sel_int_a: assert property (
      sw_ok && req_i.wdata[1] |-> ##[1:2] sys_src_o == SRC_INT_BLOCK)
      else $error("select 1x missed internal block");
   sel_pri_a: assert property (
      sw_ok && req_i.wdata[1:0] == 2'h0 |-> ##[1:2] sys_src_o == SRC_PRIMARY)
      else $error("select 00 missed primary");
   freq_a: assert property (
      ctl_wr |=> int_freq_o == $past(req_i.wdata[6:4]))
      else $error("frequency mux lagged the write");
   sleep_sec_a: assert property (
      sleep_i && secondary_osc_en_o && !req_i.wr_en |=> secondary_osc_en_o)
      else $error("secondary stopped by sleep");
   failsafe_a: assert property (
      config_word_two_i[0] && cpu_run_o && watched && src_q == sys_src_o |-> gap_q <= 4'h5)
      else $error("failed source kept");

   cover property (cpu_run_o && sys_src_o == SRC_SLOW_RC);
   cover property (wake_i);
   cover property (sw_ok);
endmodule

bind css_clock_switch css_clock_switch_asserts i_chk (
   .clock_i, .sys_rst_i, .config_word_two_i, .ticks_i, .sleep_i, .wake_i, .req_i, .rd_data_o,
   .sys_src_o, .int_freq_o, .cpu_run_o, .primary_osc_en_o, .secondary_osc_en_o, .slow_rc_en_o
);

// ==== test/tb_top.sv ====
// Purpose: self-checking bench for the clock source switch
// Assumes: oscillator model supplies ticks, 25 MHz system clock
// Notes: each scenario is a task of its own
`timescale 1ns/1ps
`include "css_cfg.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
   $display("ERROR t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb_top
   import css_pkg::*;
;
   localparam logic [3:0] A_CTL = `CSS_ADDR_CTRL;
   localparam logic [3:0] A_STA = `CSS_ADDR_STAT;
   localparam logic [3:0] A_MSK = `CSS_ADDR_MASK;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic por = 1'b1;
   logic [2:0] cw1 = 3'h1;
   logic [1:0] cw2 = 2'h0;
   logic slp = 1'b0;
   logic wak = 1'b0;
   logic p_ok = 1'b1;
   logic s_ok = 1'b1;
   css_req_t req = '0;
   css_ticks_t ticks;
   logic fast_rdy;
   logic [7:0] rd_data;
   css_src_t src;
   css_freq_t freq;
   logic run, p_en, s_en, rc_en, irq;
   int n_errors = 0;
   int checks = 0;

   // ****************************************************************
   // clock, design and oscillators
   // ****************************************************************
   initial begin
      forever #20 clk = ~clk;
   end

   css_clock_switch i_dut (
      .clock_i(clk), .sys_rst_i(rst), .por_i(por), .config_word_one_i(cw1),
      .config_word_two_i(cw2), .ticks_i(ticks), .fast_osc_ready_i(fast_rdy),
      .sleep_i(slp), .wake_i(wak), .req_i(req), .rd_data_o(rd_data), .sys_src_o(src),
      .int_freq_o(freq), .cpu_run_o(run), .primary_osc_en_o(p_en),
      .secondary_osc_en_o(s_en), .slow_rc_en_o(rc_en), .irq_o(irq)
   );

   css_osc_model i_osc (
      .clock_i(clk), .prim_en_i(p_en), .prim_ok_i(p_ok), .sec_en_i(s_en),
      .sec_ok_i(s_ok), .ticks_o(ticks), .fast_ready_o(fast_rdy)
   );

   // ****************************************************************
   // drivers
   // ****************************************************************
   task automatic reset(input logic p, input logic [2:0] c1, input logic [1:0] c2);
      @(posedge clk);
      rst <= 1'b1;
      por <= p;
      cw1 <= c1;
      cw2 <= c2;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      por <= 1'b0;
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{1'b1, 1'b0, a, d};
      @(posedge clk);
      req <= '0;
   endtask

   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      req <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge clk);
      req <= '0;
      @(negedge clk);
      d = rd_data;
   endtask

   task automatic wait_src(input css_src_t e, input int lim, output int n);
      n = 0;
      while ((src !== e || run !== 1'b1) && n < lim) begin
         @(negedge clk);
         n++;
      end
   endtask

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_boot;
      logic [7:0] d;
      int n;
      reset(1'b1, 3'h1, 2'h0);
      repeat (8) @(negedge clk);
      `CHK(run, 1'b0)
      `CHK(src, SRC_PRIMARY)
      rd(A_CTL, d);
      `CHK(d[1:0], 2'h0)
      wait_src(SRC_PRIMARY, 3000, n);
      `CHK(n > 1900 && n < 2200, 1'b1)
      rd(A_CTL, d);
      `CHK(d, 8'h0C)
   endtask

   task automatic t_switch;
      logic [1:0] sel [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
      css_src_t ex [4] = '{SRC_SECONDARY, SRC_INT_BLOCK, SRC_INT_BLOCK, SRC_PRIMARY};
      logic [7:0] d;
      for (int i = 0; i < 4; i++) begin
         wr(A_CTL, {6'h20, sel[i]});
         @(negedge clk);
         `CHK(src, ex[i])
      end
      // masked, unmasked, then write-one cleared
      wr(A_MSK, 8'h00);
      wr(A_CTL, 8'h82);
      @(negedge clk);
      `CHK(irq, 1'b0)
      wr(A_MSK, 8'h02);
      @(negedge clk);
      `CHK(irq, 1'b1)
      wr(A_STA, 8'h07);
      @(negedge clk);
      `CHK(irq, 1'b0)
      for (int f = 7; f >= 0; f--) begin
         wr(A_CTL, {1'b1, f[2:0], 4'h2});
         @(negedge clk);
         `CHK(freq, f[2:0])
      end
      rd(A_STA, d);
      `CHK(d[1], 1'b1)
      wr(A_CTL, 8'h80);
      rd(A_CTL, d);
      `CHK(d, 8'h8C)
      rd(4'hF, d);
      `CHK(d, 8'h00)
   endtask

   task automatic t_failsafe;
      logic [7:0] d;
      int n;
      reset(1'b0, 3'h1, 2'h1);
      wait_src(SRC_PRIMARY, 3000, n);
      @(posedge clk);
      p_ok <= 1'b0;
      wait_src(SRC_SLOW_RC, 100, n);
      `CHK(src, SRC_SLOW_RC)
      rd(A_STA, d);
      `CHK(d[0], 1'b1)
      p_ok <= 1'b1;
      wr(A_CTL, 8'h81);
      @(negedge clk);
      `CHK(src, SRC_SECONDARY)
      @(posedge clk);
      s_ok <= 1'b0;
      wait_src(SRC_SLOW_RC, 100, n);
      `CHK(src, SRC_SLOW_RC)
      s_ok <= 1'b1;
   endtask

   // no power-on: the latched crystal mode persists
   task automatic t_two_speed;
      logic [7:0] d;
      int n;
      reset(1'b0, 3'h3, 2'h2);
      repeat (4) @(negedge clk);
      `CHK(src, SRC_SLOW_RC)
      `CHK(run, 1'b1)
      wait_src(SRC_PRIMARY, 2200, n);
      `CHK(n >= 2020 && n <= 2052, 1'b1)
      rd(A_STA, d);
      `CHK(d[2], 1'b1)
   endtask

   task automatic t_wake;
      int n;
      wr(A_CTL, 8'h80);
      @(posedge clk);
      slp <= 1'b1;
      @(posedge clk);
      slp <= 1'b0;
      repeat (4) @(negedge clk);
      `CHK(p_en, 1'b0)
      `CHK(s_en, 1'b1)
      @(posedge clk);
      wak <= 1'b1;
      @(posedge clk);
      wak <= 1'b0;
      wait_src(SRC_SLOW_RC, 8, n);
      `CHK(src, SRC_SLOW_RC)
      wait_src(SRC_PRIMARY, 2200, n);
      `CHK(n >= 2054 && n <= 2080, 1'b1)
   endtask

   task automatic t_no_switch;
      reset(1'b1, 3'h3, 2'h2);
      repeat (4) @(negedge clk);
      `CHK(src, SRC_PRIMARY)
      `CHK(run, 1'b1)
   endtask

   task automatic wrap_up;
      if (n_errors == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // watchdog, about three and a half times the expected run
   initial begin
      repeat (30000) @(posedge clk);
      n_errors++;
      wrap_up();
   end

   initial begin
      t_boot();
      t_switch();
      t_failsafe();
      t_two_speed();
      t_wake();
      t_no_switch();
      wrap_up();
   end
endmodule
